//--- src/efiu_top.sv
// Event flag, interrupt enable and clock receiver control registers behind APB
`timescale 1ns/1ps
`include "efiu_defines.svh"

// What this block does
// - Enable bit 1 of first enable register lets FIFO warning one interrupt.
// - Enable bit 0 of first enable register lets FIFO warning two interrupt.
// - Enable bit 4 of second enable register lets auto pattern pass interrupt.
// - Enable bit 3 of second enable register lets auto pattern fail interrupt.
// - Enable bit 2 of second enable register lets sample pattern fail interrupt.
// - Flag bit 7 latches when the clock loop loses an existing lock.
// - Flag bit 6 sets when the clock loop locks; resets to zero.
// - Flag bit 5 latches when synchronisation loses an existing alignment.
// - Flag bit 4 sets when synchronisation alignment is reached.
// - Flag bit 3 sets when internal clock generation is ready.
// - Flag bit 2 latches when a software FIFO reset completes.
// - Flag bit 1 sets while FIFO pointer distance equals one.
// - Flag bit 0 sets while FIFO pointer distance equals two.
// - Second flag bit 4 latches when auto pattern check passes.
// - Second flag bit 3 latches on mismatch, clears after eight valid pairs.
// - Second flag bit 2 latches on sample pattern mismatch, never self-clears.
// - Clock control bit 7, reset 0, enables conversion clock duty correction.
// - Clock control bit 6, reset 0, enables reference clock duty correction.
// - Clock control bit 5, reset 1, enables conversion clock crossing correction.
// - Clock control bit 4, reset 1, enables reference clock crossing correction.
module efiu_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`EFIU_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	// Status inputs from the converter core, asynchronous
	input wire efiu_pkg::efiu_evt_t evt_i,
	// Outputs to the clock receiver and the interrupt pin
	output efiu_pkg::efiu_clkrx_t clkrx_q,
	output logic irq_q
);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	efiu_pkg::efiu_evt_t s_evt;
	efiu_pkg::efiu_evt_t prev_q;
	logic [7:0] ie1_q;
	logic [7:0] ie2_q;
	logic [7:0] flag1_q;
	logic [7:0] flag1_d;
	logic [7:0] flag2_q;
	logic [7:0] flag2_d;
	logic [7:0] set1;
	logic [7:0] set2;
	logic [7:0] clr1;
	logic [7:0] clr2;
	logic [3:0] pair_cnt_q;
	logic pair_evt;
	logic fail_evt;
	logic auto_clr;
	logic acc;
	logic wr_fire;
	logic hit;
	logic [7:0] rd_d;
	logic irq_d;

	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------
	// Core runs on other clocks, so every status line is retimed first
	efiu_sync #(
		.W($bits(efiu_pkg::efiu_evt_t))
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din(evt_i),
		.dout(s_evt)
	);

	// Previous synchronised value, for edge and toggle detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= '0;
		end else begin
			prev_q <= s_evt;
		end
	end

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Access phase with one wait state; write lands where pready is seen high
	assign acc = psel & penable;
	assign wr_fire = acc & pready_q & pwrite & hit & pstrb[0];

	// Address hit and read mux; unmapped words read zero
	always_comb begin
		hit = 1'b1;
		rd_d = 8'h00;
		case (paddr)
			8'(`EFIU_IDX_IE1 * 4): rd_d = ie1_q;
			8'(`EFIU_IDX_IE2 * 4): rd_d = ie2_q;
			8'(`EFIU_IDX_FLAG1 * 4): rd_d = flag1_q;
			8'(`EFIU_IDX_FLAG2 * 4): rd_d = flag2_q;
			8'(`EFIU_IDX_CLKRX * 4): rd_d = clkrx_q;
			default: hit = 1'b0;
		endcase
	end

	// Ready, error and read data all come from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= acc & ~pready_q;
			pslverr_q <= acc & ~pready_q & ~hit;
			if (acc & ~pready_q & ~pwrite) begin
				prdata_q <= {24'h00_0000, rd_d};
			end
		end
	end

	// ----------------------------------------------------------------
	// Enable registers
	// ----------------------------------------------------------------
	// First enable register, all eight bits live
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ie1_q <= `EFIU_RST_IE1;
		end else if (wr_fire && paddr == 8'(`EFIU_IDX_IE1 * 4)) begin
			ie1_q <= pwdata[7:0];
		end
	end

	// Second enable register; unused bits are not stored, so they read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ie2_q <= `EFIU_RST_IE2;
		end else if (wr_fire && paddr == 8'(`EFIU_IDX_IE2 * 4)) begin
			ie2_q <= pwdata[7:0] & `EFIU_MASK_IE2;
		end
	end

	// ----------------------------------------------------------------
	// Clock receiver control
	// ----------------------------------------------------------------
	// Drives the receiver directly; crossing correction defaults on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clkrx_q <= efiu_pkg::efiu_clkrx_t'(`EFIU_RST_CLKRX);
		end else if (wr_fire && paddr == 8'(`EFIU_IDX_CLKRX * 4)) begin
			clkrx_q <= efiu_pkg::efiu_clkrx_t'(pwdata[7:0] & `EFIU_MASK_CLKRX);
		end
	end

	// ----------------------------------------------------------------
	// Event detection
	// ----------------------------------------------------------------
	// Loss flags need a falling edge, so a loop never locked cannot report loss
	always_comb begin
		set1 = 8'h00;
		set1[`EFIU_B1_PLL_LOST] = prev_q.pll_lock & ~s_evt.pll_lock;
		set1[`EFIU_B1_PLL_LOCK] = s_evt.pll_lock;
		set1[`EFIU_B1_SYNC_LOST] = prev_q.sync_lock & ~s_evt.sync_lock;
		set1[`EFIU_B1_SYNC_LOCK] = s_evt.sync_lock;
		set1[`EFIU_B1_CLKGEN_RDY] = s_evt.clkgen_ready;
		set1[`EFIU_B1_FIFO_RST] = prev_q.fifo_rst_tgl ^ s_evt.fifo_rst_tgl;
		set1[`EFIU_B1_FIFO_WARN1] = s_evt.fifo_dist_one;
		set1[`EFIU_B1_FIFO_WARN2] = s_evt.fifo_dist_two;
	end

	// Pattern checker events arrive as toggles, one change per event
	assign pair_evt = prev_q.iq_pair_tgl ^ s_evt.iq_pair_tgl;
	assign fail_evt = prev_q.auto_fail_tgl ^ s_evt.auto_fail_tgl;

	always_comb begin
		set2 = 8'h00;
		set2[`EFIU_B2_AUTO_PASS] = prev_q.auto_pass_tgl ^ s_evt.auto_pass_tgl;
		set2[`EFIU_B2_AUTO_FAIL] = fail_evt;
		set2[`EFIU_B2_SAMPLE_FAIL] = prev_q.sample_fail_tgl ^ s_evt.sample_fail_tgl;
	end

	// ----------------------------------------------------------------
	// Auto pattern fail self-clear
	// ----------------------------------------------------------------
	// Counts valid pairs after the last mismatch; a new mismatch restarts it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pair_cnt_q <= 4'h0;
		end else if (fail_evt || !flag2_q[`EFIU_B2_AUTO_FAIL] || auto_clr) begin
			pair_cnt_q <= 4'h0;
		end else if (pair_evt) begin
			pair_cnt_q <= pair_cnt_q + 4'h1;
		end
	end

	// Eighth valid pair clears the flag, unless a mismatch lands with it
	assign auto_clr = flag2_q[`EFIU_B2_AUTO_FAIL] & pair_evt & ~fail_evt
		& (pair_cnt_q == `EFIU_AUTO_FAIL_CLR_PAIRS - 4'h1);

	// ----------------------------------------------------------------
	// Flag registers
	// ----------------------------------------------------------------
	// Write one to clear; a set in the same cycle wins so no event is lost
	always_comb begin
		clr1 = 8'h00;
		clr2 = 8'h00;
		if (wr_fire && paddr == 8'(`EFIU_IDX_FLAG1 * 4)) begin
			clr1 = pwdata[7:0];
		end
		if (wr_fire && paddr == 8'(`EFIU_IDX_FLAG2 * 4)) begin
			clr2 = pwdata[7:0];
		end
		flag1_d = (flag1_q & ~clr1) | set1;
		flag2_d = (flag2_q & ~clr2 & ~{4'h0, auto_clr, 3'h0}) | set2;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag1_q <= `EFIU_RST_FLAG;
			flag2_q <= `EFIU_RST_FLAG;
		end else begin
			flag1_q <= flag1_d;
			flag2_q <= flag2_d & `EFIU_MASK_FLAG2;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt request
	// ----------------------------------------------------------------
	// Registered, so it follows a flag or enable change by one cycle
	assign irq_d = |(flag1_q & ie1_q) | |(flag2_q & ie2_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_warn1_irq: assert property (flag1_q[1] && ie1_q[1] |=> irq_q)
		else $error("fifo warning one enabled but no interrupt");
	a_warn2_irq: assert property (flag1_q[0] && ie1_q[0] |=> irq_q)
		else $error("fifo warning two enabled but no interrupt");
	a_ie2_unused: assert property ((ie2_q & ~`EFIU_MASK_IE2) == 8'h00)
		else $error("unused enable bits hold a value");
	a_pass_irq: assert property (flag2_q[4] && ie2_q[4] |=> irq_q)
		else $error("pattern pass enabled but no interrupt");
	a_afail_irq: assert property (flag2_q[3] && ie2_q[3] |=> irq_q)
		else $error("pattern fail enabled but no interrupt");
	a_sfail_irq: assert property (flag2_q[2] && ie2_q[2] |=> irq_q)
		else $error("sample fail enabled but no interrupt");
	a_pll_lost: assert property ($fell(s_evt.pll_lock) |=> flag1_q[7])
		else $error("clock loop loss not latched");
	a_pll_lost_hold: assert property (flag1_q[7] && !clr1[7] |=> flag1_q[7])
		else $error("clock loop loss flag dropped");
	a_pll_locked: assert property (s_evt.pll_lock |=> flag1_q[6])
		else $error("clock loop lock not flagged");
	a_sync_lost: assert property ($fell(s_evt.sync_lock) |=> flag1_q[5])
		else $error("alignment loss not latched");
	a_sync_locked: assert property (s_evt.sync_lock |=> flag1_q[4])
		else $error("alignment not flagged");
	a_clkgen_rdy: assert property (s_evt.clkgen_ready |=> flag1_q[3])
		else $error("clock generation ready not flagged");
	a_fifo_rst: assert property (s_evt.fifo_rst_tgl != prev_q.fifo_rst_tgl |=> flag1_q[2])
		else $error("fifo reset completion not latched");
	a_warn1_set: assert property (s_evt.fifo_dist_one |=> flag1_q[1])
		else $error("fifo distance one not flagged");
	a_warn2_set: assert property (s_evt.fifo_dist_two |=> flag1_q[0])
		else $error("fifo distance two not flagged");
	a_pass_set: assert property (set2[4] |=> flag2_q[4])
		else $error("pattern pass not latched");
	a_afail_clear: assert property (auto_clr && !set2[3] |=> !flag2_q[3] && pair_cnt_q == 4'h0)
		else $error("pattern fail did not self-clear");
	a_afail_early: assert property (flag2_q[3] && pair_cnt_q < 4'h7 && !clr2[3] |=> flag2_q[3])
		else $error("pattern fail cleared before eight pairs");
	a_sfail_hold: assert property (flag2_q[2] && !clr2[2] |=> flag2_q[2])
		else $error("sample fail flag cleared by itself");
	a_dcc_conv: assert property (wr_fire && paddr == 8'h20 |=> clkrx_q.dcc_conv == $past(pwdata[7]))
		else $error("conversion duty correction not written");
	a_dcc_ref: assert property (wr_fire && paddr == 8'h20 |=> clkrx_q.dcc_ref == $past(pwdata[6]))
		else $error("reference duty correction not written");
	a_xcor_conv: assert property (wr_fire && paddr == 8'h20 |=> clkrx_q.xcor_conv == $past(pwdata[5]))
		else $error("conversion crossing correction not written");
	a_xcor_ref: assert property (wr_fire && paddr == 8'h20 |=> clkrx_q.xcor_ref == $past(pwdata[4]))
		else $error("reference crossing correction not written");
	a_irq_idle: assert property (!irq_d |=> !irq_q)
		else $error("interrupt raised with no enabled flag");
	a_apb_wait: assert property (acc && !pready_q |=> pready_q)
		else $error("bus access not answered after one wait state");

	// ----------------------------------------------------------------
	// Holding, writing and interrupt checks
	// ----------------------------------------------------------------
	// Latched flags survive every cycle without a clear; software relies on that
	a_sync_lost_hold: assert property (flag1_q[5] && !clr1[5] |=> flag1_q[5])
		else $error("alignment loss flag dropped");
	a_fifo_rst_hold: assert property (flag1_q[2] && !clr1[2] |=> flag1_q[2])
		else $error("fifo reset completion flag dropped");
	a_pass_hold: assert property (flag2_q[4] && !clr2[4] |=> flag2_q[4])
		else $error("pattern pass flag dropped");
	a_afail_set: assert property (set2[3] |=> flag2_q[3])
		else $error("pattern fail not latched");
	a_sfail_set: assert property (set2[2] |=> flag2_q[2])
		else $error("sample fail not latched");
	// A loss needs an earlier lock; a loop that never locked must stay silent
	a_pll_no_loss: assert property (!flag1_q[7] && !prev_q.pll_lock |=> !flag1_q[7])
		else $error("clock loop loss without earlier lock");
	a_sync_no_loss: assert property (!flag1_q[5] && !prev_q.sync_lock |=> !flag1_q[5])
		else $error("alignment loss without earlier alignment");
	// Pair counter restarts on every mismatch and never passes the clearing count
	a_fail_restart: assert property (fail_evt |=> pair_cnt_q == 4'h0)
		else $error("pair count not restarted by a mismatch");
	a_cnt_range: assert property (pair_cnt_q < `EFIU_AUTO_FAIL_CLR_PAIRS)
		else $error("pair count ran past eight");
	// Enable and clock control registers change only through a landed write
	a_ie1_write: assert property (wr_fire && paddr == 8'h10 |=> ie1_q == $past(pwdata[7:0]))
		else $error("first enable register not written");
	a_ie2_write: assert property (wr_fire && paddr == 8'h14 |=> ie2_q == ($past(pwdata[7:0]) & 8'h1C))
		else $error("second enable register not written");
	a_ie1_hold: assert property (!(wr_fire && paddr == 8'h10) |=> $stable(ie1_q))
		else $error("first enable register changed without a write");
	a_ie2_hold: assert property (!(wr_fire && paddr == 8'h14) |=> $stable(ie2_q))
		else $error("second enable register changed without a write");
	a_clkrx_hold: assert property (!(wr_fire && paddr == 8'h20) |=> $stable(clkrx_q))
		else $error("clock receiver control changed without a write");
	// Request follows the enabled flags one cycle later, both ways
	a_irq_raise: assert property ((flag1_q & ie1_q) != 8'h00 || (flag2_q & ie2_q) != 8'h00 |=> irq_q)
		else $error("enabled flag set but no interrupt");
	a_irq_quiet: assert property ((flag1_q & ie1_q) == 8'h00 && (flag2_q & ie2_q) == 8'h00 |=> !irq_q)
		else $error("interrupt with every enabled flag clear");

endmodule : efiu_top

//--- src/efiu_defines.svh
// Register indices, field positions, reset values and counts of the event flag interrupt unit
`ifndef EFIU_DEFINES_SVH
`define EFIU_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define EFIU_IDX_IE1 8'h04
`define EFIU_IDX_IE2 8'h05
`define EFIU_IDX_FLAG1 8'h06
`define EFIU_IDX_FLAG2 8'h07
`define EFIU_IDX_CLKRX 8'h08
`define EFIU_ADDR_W 8

// ----------------------------------------------------------------
// Reset values and implemented-bit masks
// ----------------------------------------------------------------
`define EFIU_RST_IE1 8'h00
`define EFIU_RST_IE2 8'h00
`define EFIU_RST_FLAG 8'h00
`define EFIU_RST_CLKRX 8'h30
`define EFIU_MASK_IE2 8'h1C
`define EFIU_MASK_FLAG2 8'h1C
`define EFIU_MASK_CLKRX 8'hF0

// ----------------------------------------------------------------
// Field positions, first flag register and first enable register
// ----------------------------------------------------------------
`define EFIU_B1_PLL_LOST 7
`define EFIU_B1_PLL_LOCK 6
`define EFIU_B1_SYNC_LOST 5
`define EFIU_B1_SYNC_LOCK 4
`define EFIU_B1_CLKGEN_RDY 3
`define EFIU_B1_FIFO_RST 2
`define EFIU_B1_FIFO_WARN1 1
`define EFIU_B1_FIFO_WARN2 0

// ----------------------------------------------------------------
// Field positions, second flag register and second enable register
// ----------------------------------------------------------------
`define EFIU_B2_AUTO_PASS 4
`define EFIU_B2_AUTO_FAIL 3
`define EFIU_B2_SAMPLE_FAIL 2

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define EFIU_AUTO_FAIL_CLR_PAIRS 4'h8
`define EFIU_SYNC_STAGES 2

`endif

//--- src/efiu_pkg.sv
// Types shared by the event flag interrupt unit
package efiu_pkg;

	// Status inputs from the converter core; levels and event toggles
	typedef struct packed {
		logic pll_lock;
		logic sync_lock;
		logic clkgen_ready;
		logic fifo_dist_one;
		logic fifo_dist_two;
		logic fifo_rst_tgl;
		logic auto_pass_tgl;
		logic auto_fail_tgl;
		logic sample_fail_tgl;
		logic iq_pair_tgl;
	} efiu_evt_t;

	// Clock receiver control byte, upper nibble used
	typedef struct packed {
		logic dcc_conv;
		logic dcc_ref;
		logic xcor_conv;
		logic xcor_ref;
		logic [3:0] rsvd;
	} efiu_clkrx_t;

endpackage : efiu_pkg

//--- src/efiu_sync.sv
// Two-flop synchroniser bank for the status inputs
`timescale 1ns/1ps
module efiu_sync #(
	parameter int W = 10
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// One independent two-flop chain per bit; first stage feeds only the second
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_q[gi] <= 1'b0;
					sync_q[gi] <= 1'b0;
				end else begin
					meta_q[gi] <= din[gi];
					sync_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate

	assign dout = sync_q;

endmodule : efiu_sync

//--- tb/tb.sv
// Self-checking bench for the event flag interrupt unit: APB registers, event flags and interrupt request
`timescale 1ns/1ps
`include "efiu_defines.svh"
module tb;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic pclk, presetn, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata_q, rnd;
	logic [3:0] pstrb;
	logic pready_q, pslverr_q, irq_q;
	efiu_pkg::efiu_evt_t evt_i;
	efiu_pkg::efiu_clkrx_t clkrx_q;
	int err_count, comparisons, cycles;
	logic [33:0] note_q[$];

	efiu_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata_q(prdata_q), .pready_q(pready_q),
		.pslverr_q(pslverr_q), .evt_i(evt_i), .clkrx_q(clkrx_q), .irq_q(irq_q));

	// Clock, 100 ns period
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// ----------------------------------------------------------------
	// Compare tasks and closing report
	// ----------------------------------------------------------------
	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk_word

	task automatic chk_flag(input string what, input logic exp, input logic seen);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %b seen %b", what, exp, seen);
		end
	endtask : chk_flag

	task automatic complete_run();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : complete_run

	// Fixed-seed pseudo-random source, advanced once per transfer
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	// ----------------------------------------------------------------
	// APB master; one idle edge before each setup so no signal is assigned twice in a step
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d, input logic [31:0] exp_d,
		input logic exp_e, input logic [3:0] st);
		int n;
		@(posedge pclk);
		note_q.push_back({wr, exp_e, exp_d});
		rnd = lfsr_next(rnd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx[5:0], 2'b00};
		pwdata <= d;
		pstrb <= st;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready_q !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			$display("BAD pready expected 1 seen 0");
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr8(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, {rnd[31:8], d}, 32'h0000_0000, 1'b0, 4'h1);
	endtask : wr8

	task automatic rd8(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, rnd, {24'h00_0000, exp}, 1'b0, 4'h1);
	endtask : rd8

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// Watcher: each completed transfer takes the oldest note off the queue
	always @(posedge pclk) begin
		if (presetn === 1'b1 && psel && penable && pready_q === 1'b1) begin
			if (note_q.size() == 0) begin
				err_count++;
				$display("BAD note_q expected 1 seen 0");
			end else begin
				if (note_q[0][33] == 1'b0) chk_word("prdata", note_q[0][31:0], prdata_q);
				chk_flag("pslverr", note_q[0][32], pslverr_q);
				void'(note_q.pop_front());
			end
		end
	end

	// Hang guard; the whole run needs well under a thousand cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int ev[9];
		logic [7:0] fr[9], fm[9], er[9];
		logic [7:0] v;
		ev = '{9, 8, 7, 6, 5, 4, 3, 2, 1};
		fr = '{6, 6, 6, 6, 6, 6, 7, 7, 7};
		fm = '{8'hC0, 8'h30, 8'h08, 8'h02, 8'h01, 8'h04, 8'h10, 8'h08, 8'h04};
		er = '{4, 4, 4, 4, 4, 4, 5, 5, 5};
		err_count = 0;
		comparisons = 0;
		cycles = 0;
		rnd = 32'h0812_82df;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
		evt_i = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values of every register and of the clock receiver outputs
		cyc(2);
		chk_word("clkrx_q", 32'h0000_0030, {24'h00_0000, clkrx_q});
		rd8(`EFIU_IDX_IE1, `EFIU_RST_IE1);
		rd8(`EFIU_IDX_IE2, `EFIU_RST_IE2);
		rd8(`EFIU_IDX_FLAG1, 8'h00);
		rd8(`EFIU_IDX_FLAG2, 8'h00);
		rd8(`EFIU_IDX_CLKRX, 8'h30);
		// Random writes; unused control bits must come out zero on clkrx_q
		repeat (4) begin
			v = rnd[7:0];
			wr8(`EFIU_IDX_IE1, v);
			rd8(`EFIU_IDX_IE1, v);
			v = rnd[7:0] & 8'h1C;
			wr8(`EFIU_IDX_IE2, v);
			rd8(`EFIU_IDX_IE2, v);
			v = rnd[7:0];
			wr8(`EFIU_IDX_CLKRX, v);
			cyc(1);
			chk_word("clkrx_q", {24'h00_0000, v & 8'hF0}, {24'h00_0000, clkrx_q});
		end
		// Strobe off drops the write; unmapped places answer with an error
		wr8(`EFIU_IDX_CLKRX, 8'h30);
		apb(1'b1, `EFIU_IDX_CLKRX, 32'h0000_00C0, 32'h0000_0000, 1'b0, 4'h0);
		rd8(`EFIU_IDX_CLKRX, 8'h30);
		apb(1'b0, 8'h00, rnd, 32'h0000_0000, 1'b1, 4'h1);
		apb(1'b1, 8'h0F, rnd, 32'h0000_0000, 1'b1, 4'h1);
		wr8(`EFIU_IDX_IE2, 8'h00);
		// Each event alone: masked gives no request, enabled gives one, clearing removes it
		for (int i = 0; i < 9; i++) begin
			evt_i[ev[i]] <= ~evt_i[ev[i]];
			cyc(6);
			if (i < 5) begin
				evt_i[ev[i]] <= 1'b0;
				cyc(6);
			end
			wr8(er[i], (er[i] == 8'h05) ? (~fm[i] & 8'h1C) : ~fm[i]);
			cyc(3);
			chk_flag("irq_q", 1'b0, irq_q);
			rd8(fr[i], fm[i]);
			wr8(er[i], fm[i]);
			cyc(3);
			chk_flag("irq_q", 1'b1, irq_q);
			wr8(fr[i], 8'hFF);
			rd8(fr[i], 8'h00);
			cyc(3);
			chk_flag("irq_q", 1'b0, irq_q);
		end
		// Auto fail clears after eight clean pairs, a new fail restarts the count; sample fail stays
		evt_i.auto_fail_tgl <= ~evt_i.auto_fail_tgl;
		evt_i.sample_fail_tgl <= ~evt_i.sample_fail_tgl;
		cyc(6);
		for (int k = 0; k < 15; k++) begin
			if (k == 7) evt_i.auto_fail_tgl <= ~evt_i.auto_fail_tgl;
			else evt_i.iq_pair_tgl <= ~evt_i.iq_pair_tgl;
			cyc(4);
		end
		cyc(2);
		rd8(`EFIU_IDX_FLAG2, 8'h0C);
		evt_i.iq_pair_tgl <= ~evt_i.iq_pair_tgl;
		cyc(6);
		rd8(`EFIU_IDX_FLAG2, 8'h04);
		wr8(`EFIU_IDX_FLAG2, 8'h04);
		rd8(`EFIU_IDX_FLAG2, 8'h00);
		// Reset in mid-run with a request pending and control bits changed
		wr8(`EFIU_IDX_IE1, 8'hFF);
		wr8(`EFIU_IDX_CLKRX, 8'hC0);
		evt_i.fifo_rst_tgl <= ~evt_i.fifo_rst_tgl;
		cyc(6);
		chk_flag("irq_q", 1'b1, irq_q);
		presetn <= 1'b0;
		cyc(2);
		chk_flag("irq_q", 1'b0, irq_q);
		chk_word("clkrx_q", 32'h0000_0030, {24'h00_0000, clkrx_q});
		presetn <= 1'b1;
		cyc(2);
		rd8(`EFIU_IDX_IE1, 8'h00);
		rd8(`EFIU_IDX_FLAG1, 8'h00);
		cyc(2);
		chk_word("notes_left", 32'h0000_0000, note_q.size());
		complete_run();
	end
endmodule : tb
